// File: common/gdc_pkg.sv
`default_nettype none
package gdc_pkg;
  // ***********************************************
  // widths and counts
  // ***********************************************
  localparam int GDC_DIGIT_W = 4;
  localparam int GDC_MUX_DIGITS = 8;
  localparam int GDC_SCAN_PULSES = 7;
  localparam int GDC_UPPER_DECADES = 6;
  localparam int GDC_IDX_W = 3;
  localparam logic [GDC_DIGIT_W-1:0] GDC_DIGIT_MAX = 4'h9;
  localparam logic [GDC_DIGIT_W-1:0] GDC_DIGIT_ZERO = 4'h0;
  localparam logic [GDC_IDX_W-1:0] GDC_IDX_FIRST = 3'h0;
  localparam logic [GDC_IDX_W-1:0] GDC_IDX_LAST = 3'h7;
  // ***********************************************
  // timing divider
  // ***********************************************
  localparam int GDC_REF_HZ = 100000;
  localparam int GDC_TICK_HZ = 10;
  localparam int GDC_TICK_DIV = GDC_REF_HZ / GDC_TICK_HZ;
  localparam int GDC_DIV_W = 14;
  localparam logic [GDC_DIV_W-1:0] GDC_HALF_DIV = GDC_DIV_W'(GDC_TICK_DIV / 2 - 1);
  // ***********************************************
  // input selection levels
  // ***********************************************
  localparam logic GDC_SEL_IF_A = 1'b0;
  localparam logic GDC_SEL_IF_B = 1'b1;
  typedef enum logic [2:0] {
    GDC_RD_IDLE = 3'b001,
    GDC_RD_SCAN = 3'b010,
    GDC_RD_DONE = 3'b100
  } gdc_rd_e;
endpackage : gdc_pkg
`default_nettype wire

// File: common/gdc_if.sv
`default_nettype none
interface gdc_if;
  logic if_sel;
  logic count_rst;
  logic latch_load;
  logic scan_clk;
  logic [3:0] mux_digit;
  logic [3:0] first_digit;
  logic first_carry;
  logic tick;
  modport device (input if_sel, count_rst, latch_load, scan_clk,
                  output mux_digit, first_digit, first_carry, tick);
  modport host (output if_sel, count_rst, latch_load, scan_clk,
                input mux_digit, first_digit, first_carry, tick);
endinterface : gdc_if
`default_nettype wire

// File: hdl/gdc_count_chain.sv
`default_nettype none
// Notes on behaviour
// - exactly one of two inputs, host-selected
// - count only while gate open, BCD out
// - first feeds second feeds third decade
// - six-decade stage clocked by third's digits
// - first digit valid after settling; carry visible
// - host reads eight decades multiplexed after count
// - multiplexer at second decade digit after reset
// - latch-load strobe captures current digit
// - seven scan pulses step remaining digits
// - first decade digit read directly
// - common reset clears all stages except the tick divider
// - reference divided by ten thousand
// - tick delivered to port adapter
module gdc_count_chain
  import gdc_pkg::*;
#(
  parameter int TICK_DIV = gdc_pkg::GDC_TICK_DIV
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset
  input wire logic if_a, // first IF pulse input (pin)
  input wire logic if_b, // second IF pulse input (pin)
  input wire logic gate, // measurement gate (pin)
  input wire logic ref_in, // reference clock input (pin)
  gdc_if.device port // parallel_port_adapter side
);
  import gdc_pkg::*;
  // ***********************************************
  // pin synchronisers
  // ***********************************************
  localparam int NPIN = 4;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  always_ff @(posedge clk_sys) begin
    s1_q <= {if_a, if_b, gate, ref_in};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  wire if_a_s = s2_q[3];
  wire if_b_s = s2_q[2];
  wire gate_s = s2_q[1];
  wire ref_rise = s2_q[0] & ~s3_q[0];
  wire [1:0] if_pair = {if_a_s, if_b_s};
  wire [1:0] if_prev = {s3_q[3], s3_q[2]};
  // ***********************************************
  // host strobes: same clock, so no synchroniser
  // ***********************************************
  logic scan_p_q;
  logic load_p_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_p_q <= 1'b0;
      load_p_q <= 1'b0;
    end else begin
      scan_p_q <= port.scan_clk;
      load_p_q <= port.latch_load;
    end
  end
  wire scan_rise = port.scan_clk & ~scan_p_q;
  wire load_rise = port.latch_load & ~load_p_q;
  // ***********************************************
  // input select and gating
  // ***********************************************
  wire rise_a = if_pair[1] & ~if_prev[1];
  wire rise_b = if_pair[0] & ~if_prev[0];
  wire sel_is_b = (port.if_sel == GDC_SEL_IF_B);
  wire sel_pulse = sel_is_b ? rise_b : rise_a;
  wire rst_all = rst | port.count_rst;
  wire cnt_en = sel_pulse & gate_s;
  // ***********************************************
  // decade cascade
  // ***********************************************
  // first decade plus the eight multiplexed ones: second, third and six upper
  localparam int NDEC = 1 + GDC_MUX_DIGITS;
  logic [GDC_DIGIT_W-1:0] dig_q [NDEC];
  logic [NDEC:0] carry;
  assign carry[0] = cnt_en;
  genvar g;
  generate
    for (g = 0; g < NDEC; g++) begin : g_dec
      wire at_max = (dig_q[g] == GDC_DIGIT_MAX);
      wire [GDC_DIGIT_W-1:0] dig_nxt = at_max ? GDC_DIGIT_ZERO : dig_q[g] + 4'h1;
      assign carry[g+1] = carry[g] & at_max;
      always_ff @(posedge clk_sys) begin
        if (rst_all) begin
          dig_q[g] <= GDC_DIGIT_ZERO;
        end else if (carry[g]) begin
          dig_q[g] <= dig_nxt;
        end
      end
    end
  endgenerate
  // ***********************************************
  // first decade direct and carry
  // ***********************************************
  logic [GDC_DIGIT_W-1:0] first_q;
  logic carry_q;
  wire first_at_max = (dig_q[0] == GDC_DIGIT_MAX);
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      first_q <= GDC_DIGIT_ZERO;
      carry_q <= 1'b0;
    end else begin
      carry_q <= first_at_max;
      // digit only follows once gate closed, so host never sees it mid-count
      if (!gate_s) begin
        first_q <= dig_q[0];
      end
    end
  end
  assign port.first_digit = first_q;
  assign port.first_carry = carry_q;
  // ***********************************************
  // digit multiplexer: decades two to nine
  // ***********************************************
  logic [GDC_IDX_W-1:0] idx_q;
  logic [GDC_IDX_W-1:0] idx_d;
  gdc_rd_e rd_q;
  gdc_rd_e rd_d;
  logic [GDC_DIGIT_W-1:0] latch_q;
  logic [GDC_DIGIT_W-1:0] latch_d;
  localparam int MUX_W = GDC_IDX_W + 1;
  // index k shows decade k+1; the first decade never enters the mux
  wire [MUX_W-1:0] mux_idx = {1'b0, idx_q} + MUX_W'(1);
  wire [GDC_DIGIT_W-1:0] mux_sel = dig_q[mux_idx];
  wire [GDC_IDX_W-1:0] idx_next = idx_q + 3'h1;
  wire idx_at_last = (idx_next == GDC_IDX_LAST);
  always_comb begin
    idx_d = idx_q;
    rd_d = rd_q;
    latch_d = latch_q;
    if (load_rise) begin
      latch_d = mux_sel;
    end
    case (rd_q)
      GDC_RD_IDLE: begin
        if (scan_rise) begin
          idx_d = idx_next;
          rd_d = GDC_RD_SCAN;
        end
      end
      GDC_RD_SCAN: begin
        if (scan_rise) begin
          idx_d = idx_next;
          if (idx_at_last) begin
            rd_d = GDC_RD_DONE;
          end
        end
      end
      GDC_RD_DONE: begin
        idx_d = idx_q;
      end
      default: begin
        rd_d = GDC_RD_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      idx_q <= GDC_IDX_FIRST;
      rd_q <= GDC_RD_IDLE;
      latch_q <= GDC_DIGIT_ZERO;
    end else begin
      idx_q <= idx_d;
      rd_q <= rd_d;
      latch_q <= latch_d;
    end
  end
  assign port.mux_digit = latch_q;
  // ***********************************************
  // tick divider: square wave at ref / TICK_DIV
  // ***********************************************
  logic [GDC_DIV_W-1:0] div_q;
  logic [GDC_DIV_W-1:0] div_d;
  logic tick_q;
  logic tick_d;
  // a period is two halves, so an odd divisor rounds down
  wire [GDC_DIV_W-1:0] half_div = GDC_DIV_W'(TICK_DIV / 2 - 1);
  wire div_wrap = (div_q == half_div);
  always_comb begin
    div_d = div_q;
    tick_d = tick_q;
    if (ref_rise) begin
      if (div_wrap) begin
        div_d = '0;
        tick_d = ~tick_q;
      end else begin
        div_d = div_q + GDC_DIV_W'(1);
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end
  assign port.tick = tick_q;
endmodule : gdc_count_chain
`default_nettype wire

// File: hdl/gdc_host_end.sv
`default_nettype none
module gdc_host_end
  import gdc_pkg::*;
#(
  parameter int STEP_CYC = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset
  input wire logic sel_b, // choose second IF input
  input wire logic clear_req, // pulse: reset chain before cycle
  input wire logic read_req, // pulse: read eight digits
  output logic busy, // read or clear in progress
  output logic [4*GDC_MUX_DIGITS-1:0] result, // digits 7..0 upper, first separate
  output logic [3:0] first_digit, // first decade digit
  output logic tick, // divided timing tick
  gdc_if.host port // toward count chain
);
  import gdc_pkg::*;
  // ***********************************************
  // sequencer
  // ***********************************************
  typedef enum logic [3:0] {
    GDC_H_IDLE = 4'b0001, GDC_H_CLR = 4'b0010, GDC_H_LOAD = 4'b0100, GDC_H_SCAN = 4'b1000
  } gdc_host_e;
  gdc_host_e st_q;
  logic [7:0] cyc_q;
  logic [3:0] n_q;
  logic rst_q, load_q, scan_q, sel_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= GDC_H_IDLE;
      cyc_q <= 8'h00;
      n_q <= 4'h0;
      rst_q <= 1'b0;
      load_q <= 1'b0;
      scan_q <= 1'b0;
      sel_q <= GDC_SEL_IF_A;
      result <= '0;
      first_digit <= 4'h0;
    end else begin
      sel_q <= sel_b ? GDC_SEL_IF_B : GDC_SEL_IF_A;
      cyc_q <= cyc_q + 8'h01;
      case (st_q)
        GDC_H_IDLE: begin
          cyc_q <= 8'h00;
          if (clear_req) begin
            st_q <= GDC_H_CLR;
            rst_q <= 1'b1;
          end else if (read_req) begin
            st_q <= GDC_H_LOAD;
            n_q <= 4'h0;
            first_digit <= port.first_digit;
          end
        end
        GDC_H_CLR: begin
          if (cyc_q == 8'(STEP_CYC)) begin
            rst_q <= 1'b0;
            st_q <= GDC_H_IDLE;
          end
        end
        GDC_H_LOAD: begin
          load_q <= (cyc_q < 8'(STEP_CYC));
          if (cyc_q == 8'(3 * STEP_CYC)) begin
            result <= {port.mux_digit, result[4*GDC_MUX_DIGITS-1:4]};
            cyc_q <= 8'h00;
            st_q <= (n_q == 4'(GDC_SCAN_PULSES)) ? GDC_H_IDLE : GDC_H_SCAN;
          end
        end
        GDC_H_SCAN: begin
          scan_q <= (cyc_q < 8'(STEP_CYC));
          if (cyc_q == 8'(3 * STEP_CYC)) begin
            n_q <= n_q + 4'h1;
            cyc_q <= 8'h00;
            st_q <= GDC_H_LOAD;
          end
        end
        default: st_q <= GDC_H_IDLE;
      endcase
    end
  end
  assign busy = (st_q != GDC_H_IDLE);
  assign tick = port.tick;
  assign port.if_sel = sel_q;
  assign port.count_rst = rst_q;
  assign port.latch_load = load_q;
  assign port.scan_clk = scan_q;
endmodule : gdc_host_end
`default_nettype wire

// File: verification/gdc_chain_sva.sv
`default_nettype none
module gdc_chain_sva (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic if_sel, // input choice
  input wire logic count_rst, // chain clear
  input wire logic latch_load, // load strobe
  input wire logic scan_clk, // digit step
  input wire logic [3:0] mux_digit, // latched digit
  input wire logic [3:0] first_digit, // first decade
  input wire logic first_carry, // carry
  input wire logic tick // timing tick
);
  import gdc_pkg::*;
  logic scan_p_q;
  logic [3:0] scan_n_q;
  always_ff @(posedge clk_sys) begin
    scan_p_q <= scan_clk;
    if (rst || count_rst) scan_n_q <= 4'h0;
    else if (scan_clk && !scan_p_q) scan_n_q <= scan_n_q + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_scan_hi; scan_clk [*3]; endsequence
  property p_mux_bcd; mux_digit <= GDC_DIGIT_MAX; endproperty
  a_mux_bcd: assert property (p_mux_bcd) else $error("mux digit not bcd");
  property p_first_bcd; first_digit <= GDC_DIGIT_MAX; endproperty
  a_first_bcd: assert property (p_first_bcd) else $error("first digit not bcd");
  property p_clear; count_rst |-> ##[1:5] (first_digit == GDC_DIGIT_ZERO); endproperty
  a_clear: assert property (p_clear) else $error("clear missed first digit");
  property p_hold; (!latch_load && !count_rst) [*6] |-> $stable(mux_digit); endproperty
  a_hold: assert property (p_hold) else $error("digit moved without load");
  property p_tick; $changed(tick) |=> $stable(tick) [*8]; endproperty
  a_tick: assert property (p_tick) else $error("tick toggles too fast");
  property p_excl; !(scan_clk && latch_load); endproperty
  a_excl: assert property (p_excl) else $error("scan and load together");
  property p_load_w; $rose(latch_load) |-> latch_load [*4]; endproperty
  a_load_w: assert property (p_load_w) else $error("load strobe too short");
  property p_scan_n; scan_n_q <= 4'h7; endproperty
  a_scan_n: assert property (p_scan_n) else $error("over seven scans");
  property p_scan_ld; $rose(scan_clk) |-> s_scan_hi ##[1:12] $rose(latch_load); endproperty
  a_scan_ld: assert property (p_scan_ld) else $error("no load after scan");
  property p_carry_clr; count_rst |=> !first_carry; endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared");
endmodule : gdc_chain_sva
`default_nettype wire

// File: verification/test_gated_decade_count_chain.sv
`default_nettype none
module test_gated_decade_count_chain;
  timeunit 1ns;
  timeprecision 1ps;
  import gdc_pkg::*;
  localparam int TDIV = 20;
  logic clk_sys = 1'b0, rst = 1'b1, if_a = 1'b0, if_b = 1'b0, gate = 1'b0, ref_in = 1'b0;
  logic sel_b = 1'b0, clear_req = 1'b0, read_req = 1'b0, busy, tick;
  logic [31:0] result;
  logic [3:0] first_digit;
  int error_cnt = 0, cmp_count = 0, seed = 32'h86904DD9, n, m, c;
  int corner[5] = '{0, 9, 10, 99, 999};
  gdc_if bus ();
  gdc_count_chain #(.TICK_DIV(TDIV)) gdc_count_chain_inst (.clk_sys(clk_sys), .rst(rst), .if_a(if_a),
    .if_b(if_b), .gate(gate), .ref_in(ref_in), .port(bus.device));
  gdc_host_end gdc_host_end_inst (.clk_sys(clk_sys), .rst(rst), .sel_b(sel_b), .clear_req(clear_req),
    .read_req(read_req), .busy(busy), .result(result), .first_digit(first_digit), .tick(tick),
    .port(bus.host));
  gdc_chain_sva gdc_chain_sva_inst (.clk_sys(clk_sys), .rst(rst), .if_sel(bus.if_sel),
    .count_rst(bus.count_rst), .latch_load(bus.latch_load), .scan_clk(bus.scan_clk),
    .mux_digit(bus.mux_digit), .first_digit(bus.first_digit), .first_carry(bus.first_carry), .tick(bus.tick));
  // ****
  // stimulus helpers
  // ****
  initial forever #2.5 clk_sys = ~clk_sys;
  // slow reference keeps edge detect reliable
  always begin
    repeat (6) @(posedge clk_sys);
    ref_in <= ~ref_in;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : step
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_idle;
    int i;
    i = 0;
    step(2);
    while (busy !== 1'b0 && i < 3000) begin
      step(1);
      i++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask : wait_idle
  task automatic burst(input int na, input int nb);
    for (int i = 0; i < na || i < nb; i++) begin
      if_a <= (i < na);
      if_b <= (i < nb);
      step(3);
      if_a <= 1'b0;
      if_b <= 1'b0;
      step(3);
    end
  endtask : burst
  task automatic to_rise(output int k);
    k = 0;
    while (tick === 1'b1 && k < 900) begin
      step(1);
      k++;
    end
    while (tick !== 1'b1 && k < 900) begin
      step(1);
      k++;
    end
  endtask : to_rise
  // mux index k holds decade k+1; the first decade is read on its own
  function automatic logic [31:0] exp_res(input int v);
    logic [31:0] r;
    int p;
    r = '0;
    p = v / 10;
    for (int k = 0; k < GDC_MUX_DIGITS; k++) begin
      r[4*k+:4] = 4'(p % 10);
      p = p / 10;
    end
    return r;
  endfunction : exp_res
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // ****
  // tests
  // ****
  initial begin
    step(20);
    rst <= 1'b0;
    step(1);
    for (int t = 0; t < 8; t++) begin
      n = (t < 5) ? corner[t] : $unsigned($random(seed)) % 400;
      m = $unsigned($random(seed)) % 400;
      sel_b <= t[0];
      clear_req <= 1'b1;
      step(1);
      clear_req <= 1'b0;
      wait_idle();
      gate <= 1'b1;
      step(6);
      if (t[0]) burst(m, n);
      else burst(n, m);
      step(6);
      gate <= 1'b0;
      step(6);
      burst(5, 5);
      step(6);
      read_req <= 1'b1;
      step(1);
      read_req <= 1'b0;
      wait_idle();
      chk("first_digit", 32'(n % 10), {28'h0, first_digit});
      chk("first_carry", {31'h0, (n % 10 == 9)}, {31'h0, bus.first_carry});
      chk("result", exp_res(n), result);
      $display("test %0d count %0d done", t, n);
    end
    to_rise(c);
    to_rise(c);
    chk("tick period", 32'(TDIV * 12), 32'(c));
    $display("tick test done");
    final_report();
  end
  initial begin
    // tests need about 20k cycles; three times that is a hang
    step(60000);
    error_cnt++;
    final_report();
  end
endmodule : test_gated_decade_count_chain
`default_nettype wire
